// >>> verilog/line_unit_consts.svh
// register offsets, field positions, reset values and timing counts of the line unit
// assumes a word-addressed plain register port with 8-bit byte offsets
`ifndef LINE_UNIT_CONSTS_SVH
`define LINE_UNIT_CONSTS_SVH
`define LU_NUM_LINES      19
`define LU_NUM_PORTS      4
`define LU_ADDR_W         8
`define LU_OFS_IRQ_MASK   8'h00
`define LU_OFS_EVT_MASK   8'h04
`define LU_OFS_RISE_EN    8'h08
`define LU_OFS_FALL_EN    8'h0C
`define LU_OFS_SOFT_TRIG  8'h10
`define LU_OFS_PENDING    8'h14
`define LU_OFS_PORT_SEL0  8'h18
`define LU_OFS_PORT_SEL1  8'h1C
`define LU_LINE_MSB       18
`define LU_RESET_MASKS    19'h0_0000
`define LU_SYNC_STAGES    2
`define LU_SEL_W          2
`endif

// >>> verilog/line_unit_pkg.sv
// types shared by the line unit modules
// assumes line_unit_consts.svh is on the include path
`include "line_unit_consts.svh"
package line_unit_pkg;
  typedef logic [`LU_LINE_MSB:0] line_vec_type;
  typedef logic [`LU_SEL_W-1:0]  port_sel_type;
  typedef enum logic [2:0] {
    ACC_IDLE  = 3'b001,
    ACC_WRITE = 3'b010,
    ACC_READ  = 3'b100
  } acc_state_type;
endpackage : line_unit_pkg

// >>> verilog/line_edge_if.sv
// interface carrying sampled line levels and detected edges between line unit modules
// assumes a single clock domain
`timescale 1ns/1ns
`default_nettype none
interface line_edge_if;
  line_unit_pkg::line_vec_type level;
  line_unit_pkg::line_vec_type rise;
  line_unit_pkg::line_vec_type fall;
  modport source (output level, output rise, output fall);
  modport sink   (input level, input rise, input fall);
endinterface : line_edge_if
`default_nettype wire

// >>> verilog/line_sync_edge.sv
// two-flop synchronisers and edge detector for every line
// assumes raw inputs are asynchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
`include "line_unit_consts.svh"
module line_sync_edge #(
  parameter int LINES = `LU_NUM_LINES
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // raw line levels
  input  wire logic [LINES-1:0] raw_i,
  // synchronised levels and edges
  line_edge_if.source           edge_o
);
  logic [LINES-1:0] meta_r;
  logic [LINES-1:0] sync_r;
  logic [LINES-1:0] prev_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= raw_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // compare with previous sample, one-cycle edge flags
  assign edge_o.level = sync_r;
  assign edge_o.rise  = sync_r & ~prev_r;
  assign edge_o.fall  = ~sync_r & prev_r;
endmodule : line_sync_edge
`default_nettype wire

// >>> verilog/line_port_mux.sv
// chooses one of four port pins for each of lines 0 to 15
// assumes the selection fields come from the register block
`timescale 1ns/1ns
`default_nettype none
module line_port_mux (
  // pins of the four ports, a/b/c/e
  input  wire logic [15:0] port_a_i,
  input  wire logic [15:0] port_b_i,
  input  wire logic [15:0] port_c_i,
  input  wire logic [15:0] port_e_i,
  // two selection bits per line
  input  wire logic [31:0] sel_i,
  // chosen pins
  output logic      [15:0] line_o
);
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      case (sel_i[2*i +: 2])
        2'h0:    line_o[i] = port_a_i[i];
        2'h1:    line_o[i] = port_b_i[i];
        2'h2:    line_o[i] = port_c_i[i];
        default: line_o[i] = port_e_i[i];
      endcase
    end
  end
endmodule : line_port_mux
`default_nettype wire

// >>> verilog/ext_line_unit.sv
// edge-triggered external interrupt and event line unit, 19 lines
// assumes one clock; pins and internal sources are asynchronous and synchronised here
`timescale 1ns/1ns
`default_nettype none
`include "line_unit_consts.svh"
//
// Contract
// - matching enabled edge with interrupt mask open sets the line pending flag and raises its interrupt.
// - interrupt request leaves only when the line's interrupt mask bit is open.
// - writing 1 to a pending bit clears it and withdraws the request.
// - matching edge with event path open gives one event pulse, pending untouched.
// - hardware event pulses need an edge selected and the event mask open.
// - soft trigger write with event path open gives one pulse, no pending.
// - soft trigger write with interrupt path open sets pending and raises interrupt.
// - event pulse output can wake the core independently of interrupts.
// - lines 0 to 15 come from same-numbered pin of port a, b, c or e.
// - line 16 supply detector, 17 clock alarm, 18 usb wake-up; 19-31 none.
// - mask bits 18:0, zero blocks, one passes, both reset to zero.
// - rising and falling triggers may both be enabled on one line.
// - writing 1 to a pending bit also clears that line's soft trigger bit.
module ext_line_unit (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // port pins
  input  wire logic [15:0]                 port_a_i,
  input  wire logic [15:0]                 port_b_i,
  input  wire logic [15:0]                 port_c_i,
  input  wire logic [15:0]                 port_e_i,
  // internal sources
  input  wire logic                        supply_voltage_detector_i,
  input  wire logic                        rtc_alarm_i,
  input  wire logic                        usb_device_wakeup_i,
  // register port
  input  wire logic [`LU_ADDR_W-1:0]       addr_i,
  input  wire logic [31:0]                 wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [31:0]                 rdata_o,
  // toward the core and its interrupt controller
  output logic      [`LU_LINE_MSB:0]       irq_o,
  output logic                             event_o,
  output logic      [`LU_LINE_MSB:0]       line_event_o
);
  localparam int LINES = `LU_NUM_LINES;

  line_unit_pkg::line_vec_type irq_line_mask_r;
  line_unit_pkg::line_vec_type event_line_mask_r;
  line_unit_pkg::line_vec_type rise_trigger_enable_r;
  line_unit_pkg::line_vec_type fall_trigger_enable_r;
  line_unit_pkg::line_vec_type soft_trigger_bit_r;
  line_unit_pkg::line_vec_type line_pending_flag_r;
  line_unit_pkg::line_vec_type line_pending_flag_nxt;
  line_unit_pkg::line_vec_type line_event_r;
  line_unit_pkg::line_vec_type line_event_nxt;
  logic [31:0]                 port_sel_r;
  logic [31:0]                 rdata_r;
  logic                        event_r;
  line_unit_pkg::acc_state_type acc_state;

  logic [15:0]                 pin_lines;
  logic [LINES-1:0]            raw_lines;
  line_unit_pkg::line_vec_type hw_hit;
  line_unit_pkg::line_vec_type wr_bits;
  line_unit_pkg::line_vec_type soft_set;
  line_unit_pkg::line_vec_type pend_clr;
  line_unit_pkg::line_vec_type polarity_chg;

  line_edge_if edges ();

  function automatic logic hit_at(input logic [`LU_ADDR_W-1:0] a,
                                  input logic [`LU_ADDR_W-1:0] ofs);
    hit_at = (a == ofs);
  endfunction : hit_at

  // source selection and synchronisation
  line_port_mux u_mux (
    .port_a_i (port_a_i),
    .port_b_i (port_b_i),
    .port_c_i (port_c_i),
    .port_e_i (port_e_i),
    .sel_i    (port_sel_r),
    .line_o   (pin_lines)
  );

  // internal sources on lines 16..18
  assign raw_lines = {usb_device_wakeup_i, rtc_alarm_i, supply_voltage_detector_i,
                      pin_lines};

  line_sync_edge #(
    .LINES (LINES)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (raw_lines),
    .edge_o  (edges)
  );

  // either selected edge counts
  assign hw_hit = (edges.rise & rise_trigger_enable_r)
                | (edges.fall & fall_trigger_enable_r);

  assign wr_bits  = wdata_i[`LU_LINE_MSB:0];
  assign soft_set = (wr_i && hit_at(addr_i, `LU_OFS_SOFT_TRIG))
                  ? (wr_bits & ~soft_trigger_bit_r) : '0;
  assign pend_clr = (wr_i && hit_at(addr_i, `LU_OFS_PENDING)) ? wr_bits : '0;

  // polarity change on either trigger register
  always_comb begin
    polarity_chg = '0;
    if (wr_i && hit_at(addr_i, `LU_OFS_RISE_EN)) begin
      polarity_chg = wr_bits ^ rise_trigger_enable_r;
    end else if (wr_i && hit_at(addr_i, `LU_OFS_FALL_EN)) begin
      polarity_chg = wr_bits ^ fall_trigger_enable_r;
    end
  end

  // access tracker
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_state <= line_unit_pkg::ACC_IDLE;
    end else begin
      case (acc_state)
        line_unit_pkg::ACC_IDLE,
        line_unit_pkg::ACC_WRITE,
        line_unit_pkg::ACC_READ: begin
          if (wr_i) begin
            acc_state <= line_unit_pkg::ACC_WRITE;
          end else if (rd_i) begin
            acc_state <= line_unit_pkg::ACC_READ;
          end else begin
            acc_state <= line_unit_pkg::ACC_IDLE;
          end
        end
        default: acc_state <= line_unit_pkg::ACC_IDLE;
      endcase
    end
  end

  // mask registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_line_mask_r   <= `LU_RESET_MASKS;
      event_line_mask_r <= `LU_RESET_MASKS;
    end else if (wr_i) begin
      if (hit_at(addr_i, `LU_OFS_IRQ_MASK)) begin
        irq_line_mask_r <= wr_bits;
      end
      if (hit_at(addr_i, `LU_OFS_EVT_MASK)) begin
        event_line_mask_r <= wr_bits;
      end
    end
  end

  // edge selection registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_trigger_enable_r <= `LU_RESET_MASKS;
      fall_trigger_enable_r <= `LU_RESET_MASKS;
    end else if (wr_i) begin
      if (hit_at(addr_i, `LU_OFS_RISE_EN)) begin
        rise_trigger_enable_r <= wr_bits;
      end
      if (hit_at(addr_i, `LU_OFS_FALL_EN)) begin
        fall_trigger_enable_r <= wr_bits;
      end
    end
  end

  // port selection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_sel_r <= 32'h0000_0000;
    end else if (wr_i) begin
      if (hit_at(addr_i, `LU_OFS_PORT_SEL0)) begin
        port_sel_r[15:0] <= wdata_i[15:0];
      end
      if (hit_at(addr_i, `LU_OFS_PORT_SEL1)) begin
        port_sel_r[31:16] <= wdata_i[15:0];
      end
    end
  end

  // soft trigger bits: set by write of 1, cleared by pending write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_trigger_bit_r <= `LU_RESET_MASKS;
    end else begin
      soft_trigger_bit_r <= (soft_trigger_bit_r | soft_set) & ~pend_clr;
    end
  end

  // pending flags: a set in the clear cycle wins
  always_comb begin
    line_pending_flag_nxt = line_pending_flag_r & ~pend_clr & ~polarity_chg;
    line_pending_flag_nxt = line_pending_flag_nxt
                          | (hw_hit & irq_line_mask_r)
                          | (soft_set & irq_line_mask_r);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_pending_flag_r <= `LU_RESET_MASKS;
    end else begin
      line_pending_flag_r <= line_pending_flag_nxt;
    end
  end

  // event pulses never touch pending flags
  assign line_event_nxt = (hw_hit | soft_set) & event_line_mask_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_event_r <= `LU_RESET_MASKS;
      event_r      <= 1'b0;
    end else begin
      line_event_r <= line_event_nxt;
      event_r      <= |line_event_nxt;
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        `LU_OFS_IRQ_MASK:  rdata_r <= {13'h0000, irq_line_mask_r};
        `LU_OFS_EVT_MASK:  rdata_r <= {13'h0000, event_line_mask_r};
        `LU_OFS_RISE_EN:   rdata_r <= {13'h0000, rise_trigger_enable_r};
        `LU_OFS_FALL_EN:   rdata_r <= {13'h0000, fall_trigger_enable_r};
        `LU_OFS_SOFT_TRIG: rdata_r <= {13'h0000, soft_trigger_bit_r};
        `LU_OFS_PENDING:   rdata_r <= {13'h0000, line_pending_flag_r};
        `LU_OFS_PORT_SEL0: rdata_r <= {16'h0000, port_sel_r[15:0]};
        `LU_OFS_PORT_SEL1: rdata_r <= {16'h0000, port_sel_r[31:16]};
        default:           rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign rdata_o      = (acc_state == line_unit_pkg::ACC_READ) ? rdata_r : 32'h0000_0000;
  assign irq_o        = line_pending_flag_r & irq_line_mask_r;
  assign event_o      = event_r;
  assign line_event_o = line_event_r;
endmodule : ext_line_unit
`default_nettype wire

// >>> bench/ext_line_unit_asserts.sv
// port-level checks of the line unit
// assumes one clock domain and line_unit_consts.svh on the include path
`timescale 1ns/1ns
`default_nettype none
`include "line_unit_consts.svh"
module ext_line_unit_asserts (
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  // watched inputs
  input wire logic [15:0]           port_a_i,
  input wire logic                  supply_voltage_detector_i,
  input wire logic [`LU_ADDR_W-1:0] addr_i,
  input wire logic [31:0]           wdata_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  // watched outputs
  input wire logic [31:0]           rdata_o,
  input wire logic [`LU_LINE_MSB:0] irq_o,
  input wire logic                  event_o,
  input wire logic [`LU_LINE_MSB:0] line_event_o
);
  logic [`LU_LINE_MSB:0] w_low;
  assign w_low = wdata_i[`LU_LINE_MSB:0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_reserved_zero: assert property (rdata_o[31:19] == 13'h0)
    else $error("reserved read bits not zero");
  a_unmapped_zero: assert property (rd_i && addr_i > `LU_OFS_PORT_SEL1 |=> rdata_o == 0)
    else $error("unmapped read not zero");
  a_event_or_lines: assert property (event_o == |line_event_o)
    else $error("event output differs from line events");
  a_pulse_single: assert property ((line_event_o & $past(line_event_o)) == 0)
    else $error("event pulse longer than one cycle");
  a_pend_clear: assert property (wr_i && addr_i == `LU_OFS_PENDING |=> (irq_o & $past(w_low)) == 0)
    else $error("pending write did not withdraw request");
  a_irq_mask: assert property (wr_i && addr_i == `LU_OFS_IRQ_MASK |=> (irq_o & ~$past(w_low)) == 0)
    else $error("masked line requests interrupt");
  a_event_cause: assert property (line_event_o[16] |-> $past(wr_i)
    || $past(supply_voltage_detector_i, 3) != $past(supply_voltage_detector_i, 4))
    else $error("line 16 event without cause");
  a_irq_cause: assert property ($rose(irq_o[3]) |-> $past(wr_i)
    || $past(port_a_i[3], 3) != $past(port_a_i[3], 4))
    else $error("line 3 request without cause");
endmodule : ext_line_unit_asserts
bind ext_line_unit ext_line_unit_asserts u_asserts (.clk_i, .rst_n_i, .port_a_i,
  .supply_voltage_detector_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o,
  .event_o, .line_event_o);
`default_nettype wire

// >>> bench/core_wake_model.sv
// core side model: wakes from event sleep on each event pulse
// assumes the event output is a one-cycle pulse on clk_i
`timescale 1ns/1ns
`default_nettype none
module core_wake_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // from the line unit
  input  wire logic event_i,
  // wake count
  output var  int   wakes_o
);
  // one wake per pulse; no flag is cleared after waking
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) wakes_o <= 0;
    else if (event_i) wakes_o <= wakes_o + 1;
  end
endmodule : core_wake_model
`default_nettype wire

// >>> bench/ext_line_unit_bench.sv
// self-checking bench of the line unit
// assumes the checker is bound and the core model sits on the event output
`timescale 1ns/1ns
`default_nettype none
`include "line_unit_consts.svh"
module ext_line_unit_bench;
  logic                  clk_i, rst_n_i, wr, rd, sv, rtc, usb, ev;
  logic [15:0]           pa, pb, pc, pe;
  logic [`LU_ADDR_W-1:0] addr;
  logic [31:0]           wdata, rdata, d;
  logic [18:0]           irq, lev;
  int                    wakes, w0, n_errors, compares;
  ext_line_unit u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .port_a_i(pa), .port_b_i(pb),
    .port_c_i(pc), .port_e_i(pe), .supply_voltage_detector_i(sv), .rtc_alarm_i(rtc),
    .usb_device_wakeup_i(usb), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .irq_o(irq), .event_o(ev), .line_event_o(lev));
  core_wake_model u_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .event_i(ev), .wakes_o(wakes));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic t_reset();
    for (int a = 0; a <= 32; a += 4) begin
      rd_reg(8'(a));
      chk(d, 0);
    end
    chk(irq, 0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_hw_irq();
    w0 = wakes;
    wr_reg(`LU_OFS_IRQ_MASK, 32'h0000_0008);
    wr_reg(`LU_OFS_RISE_EN, 32'h0000_0018);
    @(posedge clk_i);
    pa[4:3] <= 2'b11;
    settle(3);
    chk(irq, 32'h0000_0008);
    rd_reg(`LU_OFS_PENDING);
    chk(d, 32'h0000_0008);
    chk(wakes - w0, 0);
    wr_reg(`LU_OFS_PENDING, 32'h0000_0008);
    #1 chk(irq, 0);
    $display("t_hw_irq done");
  endtask : t_hw_irq
  task automatic t_polarity();
    @(posedge clk_i);
    pa[3] <= 1'b0;
    @(posedge clk_i);
    pa[3] <= 1'b1;
    settle(3);
    chk(irq, 32'h0000_0008);
    wr_reg(`LU_OFS_FALL_EN, 32'h0000_0008);
    #1 chk(irq, 0);
    @(posedge clk_i);
    pa[3] <= 1'b0;
    settle(3);
    chk(irq, 32'h0000_0008);
    wr_reg(`LU_OFS_PENDING, 32'h0000_0008);
    $display("t_polarity done");
  endtask : t_polarity
  task automatic t_event();
    w0 = wakes;
    wr_reg(`LU_OFS_EVT_MASK, 32'h0007_0000);
    wr_reg(`LU_OFS_RISE_EN, 32'h0007_0018);
    wr_reg(`LU_OFS_FALL_EN, 32'h0007_0008);
    for (int i = 0; i < 3; i++) begin
      for (int v = 1; v >= 0; v--) begin
        @(posedge clk_i);
        {usb, rtc, sv} <= 3'(v << i);
        settle(3);
        chk(lev, 32'(1) << (16 + i));
        settle(1);
        chk(lev, 0);
      end
    end
    chk(wakes - w0, 6);
    rd_reg(`LU_OFS_PENDING);
    chk(d, 0);
    $display("t_event done");
  endtask : t_event
  task automatic t_soft();
    w0 = wakes;
    wr_reg(`LU_OFS_EVT_MASK, 32'h0000_0040);
    wr_reg(`LU_OFS_IRQ_MASK, 32'h0000_0080);
    wr_reg(`LU_OFS_SOFT_TRIG, 32'h0000_00C0);
    #1 chk(lev, 32'h0000_0040);
    chk(irq, 32'h0000_0080);
    rd_reg(`LU_OFS_PENDING);
    chk(d, 32'h0000_0080);
    chk(wakes - w0, 1);
    wr_reg(`LU_OFS_PENDING, 32'h0000_00C0);
    rd_reg(`LU_OFS_SOFT_TRIG);
    chk(d, 0);
    $display("t_soft done");
  endtask : t_soft
  task automatic t_port_sel();
    wr_reg(`LU_OFS_PORT_SEL1, 32'h0000_0036);
    rd_reg(`LU_OFS_PORT_SEL1);
    chk(d, 32'h0000_0036);
    wr_reg(`LU_OFS_IRQ_MASK, 32'h0000_0700);
    wr_reg(`LU_OFS_RISE_EN, 32'h0000_0700);
    @(posedge clk_i);
    pa[10:8] <= 3'b111;
    settle(3);
    chk(irq, 0);
    @(posedge clk_i);
    {pe[10], pb[9], pc[8]} <= 3'b111;
    settle(3);
    chk(irq, 32'h0000_0700);
    $display("t_port_sel done");
  endtask : t_port_sel
  initial begin
    {rst_n_i, wr, rd, sv, rtc, usb} = '0;
    {pa, pb, pc, pe, addr, wdata} = '0;
    n_errors = 0;
    compares = 0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_hw_irq();
    t_polarity();
    t_event();
    t_soft();
    t_port_sel();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    test_done();
  end
endmodule : ext_line_unit_bench
`default_nettype wire
